// ==== mchd_consts.svh ====
// Notes on behaviour
// - Frame +8 holds the virtual address register
// - Codes 10,11 give failing read address
// - Frame +12 holds last fetch address plus four
// - Frame +16 bit 22 holds timer enable
// - Frame +16 low half holds soft summary
// - State bits 31:24 hold PC delta
// - State bits 20:18 hold access type
// - State bits 17:16 hold data length
// - State holds opcode and destination register
// - Vector table found through base register
// - Machine check dispatches via offset 04
// - Access and translation faults use 20, 24
// - Vector index from supplied bits 15:2
// - Bit 1 clear: priority equals request level
// - Halt saves PC and status word
// - Status bit 14 set when status invalid, except on power-up halt
// - Saved status layout with mapping and code
// - Halt loads status word 041F0000
// - Halt restarts at E0040000, mapping off
// - Halt code 3 clears timer, summary, trap
// - Halt codes 2, 3 and 6
// - Nested fault halt codes 4 through 13
// - Frame begins with byte count 24
// - Frame +4 bit 31 is restart flag
`ifndef MCHD_CONSTS_SVH
`define MCHD_CONSTS_SVH
`define MCHD_ADR_VBASE 8'h00
`define MCHD_ADR_TIMER 8'h04
`define MCHD_ADR_SOFT_IRQ_SUMMARY 8'h08
`define MCHD_ADR_ASYNC_TRAP_LEVEL 8'h0C
`define MCHD_ADR_HALT_SAVED_PC 8'h10
`define MCHD_ADR_SAVST 8'h14
`define MCHD_ADR_MCSTAT 8'h18
`define MCHD_FRAME_HI 3'h1
`define MCHD_FRAME_WORDS 7
`define MCHD_FRAME_BYTES 32'h0000_0018
`define MCHD_HALT_PSL 32'h041F_0000
`define MCHD_HALT_PC 32'hE004_0000
`define MCHD_VEC_MCHECK 16'h0004
`define MCHD_VEC_ACV 16'h0020
`define MCHD_VEC_TNV 16'h0024
`define MCHD_PAR_MCHECK 4'h6
`define MCHD_PAR_FAULT 4'h2
`define MCHD_PAR_IRQ 4'h0
`define MCHD_MC_RD_CACHE 16'h0010
`define MCHD_MC_RD_BUS 16'h0011
`define MCHD_TIMER_IE_BIT 6
`define MCHD_FRAME_IE_BIT 22
`define MCHD_HC_EXT 6'h02
`define MCHD_HC_PWRUP 6'h03
`define MCHD_HC_HALTI 6'h06
`define MCHD_HC_VEC11 6'h07
`define MCHD_HC_VEC10 6'h08
`define MCHD_HC_FLT_MC 6'h10
`define MCHD_HC_FLT_KS 6'h11
`define MCHD_HC_MC_MC 6'h12
`define MCHD_HC_MC_KS 6'h13
`endif

// ==== mchd_pkg.sv ====
`default_nettype none
package mchd_pkg;
  typedef enum logic [1:0] {
    MCHD_H_IDLE = 2'h0,
    MCHD_H_SAVE = 2'h1,
    MCHD_H_LOAD = 2'h3
  } mchd_halt_t;

  typedef struct packed {
    logic [6:0][31:0] word;
  } mchd_frame_st_t;

  typedef struct packed {
    mchd_halt_t hst;
    logic pwrup;
    logic [5:0] hcode;
    logic hpin_s1;
    logic hpin_s2;
    logic hpin_s3;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic [4:0] lvl_s1;
    logic [4:0] lvl_s2;
    logic [15:0] vec_s1;
    logic [15:0] vec_s2;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] vbase;
    logic [31:0] timer;
    logic [15:0] soft_irq_summary;
    logic [2:0] async_trap_level;
    logic [31:0] halt_saved_pc;
    logic [31:0] savst;
    logic mc_active;
    logic dispatch;
    logic [31:0] daddr;
    logic [4:0] prio;
    logic [3:0] params;
    logic halt_pulse;
    logic [31:0] pc_load;
    logic [31:0] psl_load;
    logic mapping_enable;
  } mchd_top_st_t;
endpackage
`default_nettype wire

// ==== mchd_frame_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface mchd_frame_if (
  input wire logic clk,
  input wire logic rst
);
  logic capture;
  logic [15:0] code;
  logic restart;
  logic [31:0] va;
  logic [31:0] read_va;
  logic [31:0] fetch_va;
  logic timer_ie;
  logic [15:0] soft_irq_summary;
  logic [31:0] pc;
  logic [31:0] backup_pc;
  logic [2:0] access_type;
  logic [1:0] data_length;
  logic [7:0] opcode;
  logic [3:0] dest_reg;
  logic [6:0][31:0] frame;

  modport builder (
    input clk, rst, capture, code, restart, va, read_va, fetch_va, timer_ie, soft_irq_summary,
    input pc, backup_pc, access_type, data_length, opcode, dest_reg,
    output frame
  );
  modport owner (
    output capture, code, restart, va, read_va, fetch_va, timer_ie, soft_irq_summary,
    output pc, backup_pc, access_type, data_length, opcode, dest_reg,
    input frame
  );
endinterface
`default_nettype wire

// ==== mchd_frame_build.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mchd_consts.svh"
module mchd_frame_build (
  mchd_frame_if.builder f
);
  mchd_pkg::mchd_frame_st_t s_reg;
  mchd_pkg::mchd_frame_st_t s_next;
  logic [31:0] delta;

  assign delta = f.pc - f.backup_pc;

  always_comb
  begin
    s_next = s_reg;
    if (f.capture)
    begin
      s_next.word[0] = `MCHD_FRAME_BYTES;
      s_next.word[1] = {f.restart, 15'h0000, f.code};
      s_next.word[2] = f.va;
      if (f.code == `MCHD_MC_RD_CACHE || f.code == `MCHD_MC_RD_BUS)
        s_next.word[2] = f.read_va;
      s_next.word[3] = f.fetch_va + 32'h0000_0004;
      s_next.word[4] = {9'h000, f.timer_ie, 6'h00, f.soft_irq_summary};
      s_next.word[5] = {delta[7:0], 3'h0, f.access_type, f.data_length,
                        f.opcode, 4'h0, f.dest_reg};
      s_next.word[6] = 32'h0000_0000;
    end
  end

  always_ff @(posedge f.clk)
  begin
    if (f.rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign f.frame = s_reg.word;

  fetch_plus_four_a: assert property (@(posedge f.clk) disable iff (f.rst)
    f.capture |=> f.frame[3] == $past(f.fetch_va) + 32'h0000_0004)
    else $error("Fetch address word wrong");
  timer_bit_a: assert property (@(posedge f.clk) disable iff (f.rst)
    f.capture |=> f.frame[4][`MCHD_FRAME_IE_BIT] == $past(f.timer_ie)
      && f.frame[4][15:0] == $past(f.soft_irq_summary))
    else $error("Timer or summary word wrong");
endmodule
`default_nettype wire

// ==== mchd_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mchd_consts.svh"
module mchd_top (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic MCHECK_I,
  input wire logic [15:0] MCHECK_CODE_I,
  input wire logic RESTART_OK_I,
  input wire logic [31:0] VA_I,
  input wire logic [31:0] READ_VA_I,
  input wire logic [31:0] FETCH_VA_I,
  input wire logic [31:0] PC_I,
  input wire logic [31:0] BACKUP_PC_I,
  input wire logic [2:0] ACCESS_TYPE_I,
  input wire logic [1:0] DATA_LENGTH_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [3:0] DEST_REG_I,
  input wire logic FAULT_ACV_I,
  input wire logic FAULT_TNV_I,
  input wire logic KSNV_ACTIVE_I,
  input wire logic HALT_INSTR_I,
  input wire logic KERNEL_MODE_I,
  input wire logic NESTED_HALT_I,
  input wire logic [5:0] NESTED_CODE_I,
  input wire logic [31:0] PSL_I,
  input wire logic PSL_VALID_I,
  input wire logic MAPPING_ENABLE_I,
  input wire logic HALT_PIN_N_I,
  input wire logic IRQ_REQ_I,
  input wire logic [4:0] IRQ_LEVEL_I,
  input wire logic [15:0] IRQ_VECTOR_I,
  output logic DISPATCH_O,
  output logic [31:0] DISPATCH_ADDR_O,
  output logic [4:0] NEW_PRIORITY_O,
  output logic [3:0] PARAM_COUNT_O,
  output logic HALT_O,
  output logic [31:0] PC_LOAD_O,
  output logic [31:0] PSL_LOAD_O,
  output logic MAPPING_ENABLE_O
);
  mchd_pkg::mchd_top_st_t s_reg;
  mchd_pkg::mchd_top_st_t s_next;
  logic cap_frame;
  logic hgo;
  logic [5:0] hc;
  logic dgo;
  logic [15:0] doff;
  logic [3:0] dpar;
  logic [4:0] dprio;
  logic [31:0] soft_irq_summary_merged;

  mchd_frame_if fif (
    .clk(CLK_SYS_I),
    .rst(RESET_I)
  );

  assign fif.capture = cap_frame;
  assign fif.code = MCHECK_CODE_I;
  assign fif.restart = RESTART_OK_I;
  assign fif.va = VA_I;
  assign fif.read_va = READ_VA_I;
  assign fif.fetch_va = FETCH_VA_I;
  assign fif.timer_ie = s_reg.timer[`MCHD_TIMER_IE_BIT];
  assign fif.soft_irq_summary = s_reg.soft_irq_summary;
  assign fif.pc = PC_I;
  assign fif.backup_pc = BACKUP_PC_I;
  assign fif.access_type = ACCESS_TYPE_I;
  assign fif.data_length = DATA_LENGTH_I;
  assign fif.opcode = OPCODE_I;
  assign fif.dest_reg = DEST_REG_I;

  mchd_frame_build u_frame (
    .f(fif.builder)
  );

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    return r;
  endfunction

  assign soft_irq_summary_merged = lane_merge({16'h0000, s_reg.soft_irq_summary}, DAT_I, SEL_I);

  always_comb
  begin
    s_next = s_reg;
    cap_frame = 1'b0;
    hgo = 1'b0;
    hc = 6'h00;
    dgo = 1'b0;
    doff = 16'h0000;
    dpar = `MCHD_PAR_IRQ;
    dprio = s_reg.prio;
    s_next.ack = 1'b0;
    s_next.dispatch = 1'b0;
    s_next.halt_pulse = 1'b0;
    // Pin synchronisers, third stage for edges
    s_next.hpin_s1 = HALT_PIN_N_I;
    s_next.hpin_s2 = s_reg.hpin_s1;
    s_next.hpin_s3 = s_reg.hpin_s2;
    s_next.req_s1 = IRQ_REQ_I;
    s_next.req_s2 = s_reg.req_s1;
    s_next.req_s3 = s_reg.req_s2;
    s_next.lvl_s1 = IRQ_LEVEL_I;
    s_next.lvl_s2 = s_reg.lvl_s1;
    s_next.vec_s1 = IRQ_VECTOR_I;
    s_next.vec_s2 = s_reg.vec_s1;

    if (CYC_I && STB_I && !s_reg.ack)
    begin
      s_next.ack = 1'b1;
      s_next.rdat = 32'h0000_0000;
      if (WE_I)
      begin
        if (ADR_I == `MCHD_ADR_VBASE)
          s_next.vbase = lane_merge(s_reg.vbase, DAT_I, SEL_I);
        else if (ADR_I == `MCHD_ADR_TIMER)
          s_next.timer = lane_merge(s_reg.timer, DAT_I, SEL_I);
        else if (ADR_I == `MCHD_ADR_SOFT_IRQ_SUMMARY)
          s_next.soft_irq_summary = soft_irq_summary_merged[15:0];
        else if (ADR_I == `MCHD_ADR_ASYNC_TRAP_LEVEL && SEL_I[0])
          s_next.async_trap_level = DAT_I[2:0];
        else if (ADR_I == `MCHD_ADR_MCSTAT && SEL_I[0] && DAT_I[0])
          s_next.mc_active = 1'b0;
      end
      else
      begin
        if (ADR_I == `MCHD_ADR_VBASE)
          s_next.rdat = s_reg.vbase;
        else if (ADR_I == `MCHD_ADR_TIMER)
          s_next.rdat = s_reg.timer;
        else if (ADR_I == `MCHD_ADR_SOFT_IRQ_SUMMARY)
          s_next.rdat = {16'h0000, s_reg.soft_irq_summary};
        else if (ADR_I == `MCHD_ADR_ASYNC_TRAP_LEVEL)
          s_next.rdat = {29'h0000_0000, s_reg.async_trap_level};
        else if (ADR_I == `MCHD_ADR_HALT_SAVED_PC)
          s_next.rdat = s_reg.halt_saved_pc;
        else if (ADR_I == `MCHD_ADR_SAVST)
          s_next.rdat = s_reg.savst;
        else if (ADR_I == `MCHD_ADR_MCSTAT)
          s_next.rdat = {31'h0000_0000, s_reg.mc_active};
        else if (ADR_I[7:5] == `MCHD_FRAME_HI && ADR_I[4:2] != 3'h7)
          s_next.rdat = fif.frame[ADR_I[4:2]];
      end
    end

    case (s_reg.hst)
      mchd_pkg::MCHD_H_IDLE:
      begin
        if (s_reg.pwrup)
        begin
          hgo = 1'b1;
          hc = `MCHD_HC_PWRUP;
        end
        else if (s_reg.hpin_s3 && !s_reg.hpin_s2)
        begin
          hgo = 1'b1;
          hc = `MCHD_HC_EXT;
        end
        else if (NESTED_HALT_I)
        begin
          hgo = 1'b1;
          hc = NESTED_CODE_I;
        end
        else if (MCHECK_I && (s_reg.mc_active || KSNV_ACTIVE_I))
        begin
          hgo = 1'b1;
          hc = s_reg.mc_active ? `MCHD_HC_MC_MC : `MCHD_HC_MC_KS;
        end
        else if ((FAULT_ACV_I || FAULT_TNV_I) && (s_reg.mc_active || KSNV_ACTIVE_I))
        begin
          hgo = 1'b1;
          hc = s_reg.mc_active ? `MCHD_HC_FLT_MC : `MCHD_HC_FLT_KS;
        end
        else if (HALT_INSTR_I && KERNEL_MODE_I)
        begin
          hgo = 1'b1;
          hc = `MCHD_HC_HALTI;
        end
        else if (MCHECK_I)
        begin
          dgo = 1'b1;
          doff = `MCHD_VEC_MCHECK;
          dpar = `MCHD_PAR_MCHECK;
          cap_frame = 1'b1;
          s_next.mc_active = 1'b1;
        end
        else if (FAULT_ACV_I || FAULT_TNV_I)
        begin
          dgo = 1'b1;
          doff = FAULT_ACV_I ? `MCHD_VEC_ACV : `MCHD_VEC_TNV;
          dpar = `MCHD_PAR_FAULT;
        end
        else if (s_reg.req_s2 && !s_reg.req_s3)
        begin
          if (s_reg.vec_s2[1:0] == 2'h3)
          begin
            hgo = 1'b1;
            hc = `MCHD_HC_VEC11;
          end
          else if (s_reg.vec_s2[1:0] == 2'h2)
          begin
            hgo = 1'b1;
            hc = `MCHD_HC_VEC10;
          end
          else
          begin
            dgo = 1'b1;
            doff = {s_reg.vec_s2[15:2], 2'h0};
            dprio = s_reg.lvl_s2;
          end
        end
        if (hgo)
        begin
          s_next.hst = mchd_pkg::MCHD_H_SAVE;
          s_next.hcode = hc;
          s_next.pwrup = 1'b0;
        end
        if (dgo)
        begin
          s_next.dispatch = 1'b1;
          s_next.daddr = {s_reg.vbase[31:2], 2'h0} + {16'h0000, doff};
          s_next.params = dpar;
          s_next.prio = dprio;
        end
      end
      mchd_pkg::MCHD_H_SAVE:
      begin
        s_next.halt_saved_pc = PC_I;
        s_next.savst = {PSL_I[31:16], MAPPING_ENABLE_I,
                        ~PSL_VALID_I && (s_reg.hcode != `MCHD_HC_PWRUP),
                        s_reg.hcode, PSL_I[7:0]};
        s_next.hst = mchd_pkg::MCHD_H_LOAD;
      end
      mchd_pkg::MCHD_H_LOAD:
      begin
        s_next.psl_load = `MCHD_HALT_PSL;
        s_next.pc_load = `MCHD_HALT_PC;
        s_next.mapping_enable = 1'b0;
        s_next.halt_pulse = 1'b1;
        s_next.mc_active = 1'b0;
        if (s_reg.hcode == `MCHD_HC_PWRUP)
        begin
          s_next.timer = 32'h0000_0000;
          s_next.soft_irq_summary = 16'h0000;
          s_next.async_trap_level = 3'h0;
        end
        s_next.hst = mchd_pkg::MCHD_H_IDLE;
      end
      default:
        s_next.hst = mchd_pkg::MCHD_H_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    // Timer, summary and trap level are left for the power-up halt to clear
    if (RESET_I)
      s_reg <= '{hst: mchd_pkg::MCHD_H_IDLE, pwrup: 1'b1, hpin_s1: 1'b1, hpin_s2: 1'b1,
                 hpin_s3: 1'b1, timer: s_reg.timer, soft_irq_summary: s_reg.soft_irq_summary, async_trap_level: s_reg.async_trap_level,
                 default: '0};
    else
      s_reg <= s_next;
  end

  assign DAT_O = s_reg.rdat;
  assign ACK_O = s_reg.ack;
  assign DISPATCH_O = s_reg.dispatch;
  assign DISPATCH_ADDR_O = s_reg.daddr;
  assign NEW_PRIORITY_O = s_reg.prio;
  assign PARAM_COUNT_O = s_reg.params;
  assign HALT_O = s_reg.halt_pulse;
  assign PC_LOAD_O = s_reg.pc_load;
  assign PSL_LOAD_O = s_reg.psl_load;
  assign MAPPING_ENABLE_O = s_reg.mapping_enable;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  bus_ack_once_a: assert property (ACK_O |=> !ACK_O)
    else $error("Ack held longer than one cycle");
  halt_state_load_a: assert property (
    HALT_O |-> PSL_LOAD_O == `MCHD_HALT_PSL && PC_LOAD_O == `MCHD_HALT_PC && !MAPPING_ENABLE_O)
    else $error("Halt restart state wrong");
  halt_seq_len_a: assert property (
    s_reg.hst == mchd_pkg::MCHD_H_SAVE |=> s_reg.hst == mchd_pkg::MCHD_H_LOAD ##1 HALT_O)
    else $error("Halt sequence timing wrong");
  saved_code_a: assert property (
    HALT_O |-> s_reg.savst[13:8] == s_reg.hcode)
    else $error("Saved halt code wrong");
  pwrup_clear_a: assert property (
    HALT_O && s_reg.hcode == `MCHD_HC_PWRUP |-> s_reg.timer == 32'h0000_0000
      && s_reg.soft_irq_summary == 16'h0000 && s_reg.async_trap_level == 3'h0)
    else $error("Power-up halt did not clear");
  mcheck_vector_a: assert property (
    s_reg.hst == mchd_pkg::MCHD_H_IDLE && !s_reg.pwrup && s_reg.hpin_s2 && MCHECK_I
      && !NESTED_HALT_I && !s_reg.mc_active && !KSNV_ACTIVE_I
      && !(HALT_INSTR_I && KERNEL_MODE_I)
    |=> DISPATCH_O && PARAM_COUNT_O == 4'h6
      && DISPATCH_ADDR_O == {$past(s_reg.vbase[31:2]), 2'h0} + 32'h0000_0004)
    else $error("Machine check dispatch wrong");
  nested_mcheck_a: assert property (
    s_reg.hst == mchd_pkg::MCHD_H_IDLE && !s_reg.pwrup && s_reg.hpin_s2
      && !NESTED_HALT_I && MCHECK_I && s_reg.mc_active
    |=> s_reg.hst == mchd_pkg::MCHD_H_SAVE && s_reg.hcode == 6'h12)
    else $error("Nested machine check not halted");
  irq_level_a: assert property (
    DISPATCH_O && PARAM_COUNT_O == 4'h0 |-> NEW_PRIORITY_O == $past(s_reg.lvl_s2))
    else $error("Interrupt priority wrong");
endmodule
`default_nettype wire

// ==== mchd_irq_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module mchd_irq_src (
  input wire logic clk_i,
  output logic req_o,
  output logic [4:0] level_o,
  output logic [15:0] vector_o
);
  initial
  begin
    req_o = 1'b0;
    level_o = 5'h00;
    vector_o = 16'h0000;
  end

  task automatic send(input logic [4:0] lvl, input logic [15:0] vec, input int settle);
    @(posedge clk_i);
    level_o <= lvl;
    vector_o <= vec;
    repeat (settle) @(posedge clk_i);
    req_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    req_o <= 1'b0;
    // Stale values never linger
    level_o <= ~lvl;
    vector_o <= ~vec;
  endtask
endmodule
`default_nettype wire

// ==== mchd_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin comparisons++; if ((g) !== (e)) \
  begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam logic [31:0] BASE = 32'h0000_2200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [4:0] ev = 5'h00;
  logic [15:0] code = 16'h0;
  logic rok = 1'b0, ksnv = 1'b0, kmode = 1'b0, svalid = 1'b1, map_en = 1'b0, hpin_n = 1'b1;
  logic [31:0] faddr = 32'h0, raddr = 32'h0, fetch = 32'h0, pc = 32'h0, bpc = 32'h0;
  logic [31:0] status_w = 32'h0;
  logic [2:0] acc = 3'h0;
  logic [1:0] dlen = 2'h0;
  logic [7:0] opc = 8'h0;
  logic [3:0] dreg = 4'h0;
  logic [5:0] ncode = 6'h0;
  logic [2:0] acc_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic [31:0] q, rdat, daddr, pcl, stl;
  logic ack, disp, hlt, mapo, ireq;
  logic [4:0] prio, ilvl;
  logic [3:0] npar;
  logic [15:0] ivec;
  int comparisons = 0;
  int n_mismatch = 0;

  always #50 clk = ~clk;

  mchd_irq_src irq (.clk_i(clk), .req_o(ireq), .level_o(ilvl), .vector_o(ivec));

  mchd_top uut (
    .CLK_SYS_I(clk), .RESET_I(rst), .ADR_I(adr), .DAT_I(wdat), .SEL_I(4'hF),
    .WE_I(wen), .STB_I(stb), .CYC_I(cyc), .DAT_O(rdat), .ACK_O(ack),
    .MCHECK_I(ev[0]), .MCHECK_CODE_I(code), .RESTART_OK_I(rok), .VA_I(faddr),
    .READ_VA_I(raddr), .FETCH_VA_I(fetch), .PC_I(pc), .BACKUP_PC_I(bpc),
    .ACCESS_TYPE_I(acc), .DATA_LENGTH_I(dlen), .OPCODE_I(opc), .DEST_REG_I(dreg),
    .FAULT_ACV_I(ev[1]), .FAULT_TNV_I(ev[2]), .KSNV_ACTIVE_I(ksnv),
    .HALT_INSTR_I(ev[3]), .KERNEL_MODE_I(kmode), .NESTED_HALT_I(ev[4]),
    .NESTED_CODE_I(ncode), .PSL_I(status_w), .PSL_VALID_I(svalid), .MAPPING_ENABLE_I(map_en),
    .HALT_PIN_N_I(hpin_n), .IRQ_REQ_I(ireq), .IRQ_LEVEL_I(ilvl), .IRQ_VECTOR_I(ivec),
    .DISPATCH_O(disp), .DISPATCH_ADDR_O(daddr), .NEW_PRIORITY_O(prio),
    .PARAM_COUNT_O(npar), .HALT_O(hlt), .PC_LOAD_O(pcl), .PSL_LOAD_O(stl), .MAPPING_ENABLE_O(mapo)
  );

  task automatic complete_run;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    `CHK(ack, 1'b1)
    cyc <= 1'b0;
    stb <= 1'b0;
    wen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  task automatic wait_ev(input bit h);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((h ? hlt : disp) !== 1'b1 && n < 40);
    `CHK(h ? hlt : disp, 1'b1)
  endtask

  task automatic chk_disp(input logic [31:0] a, input logic [4:0] p, input logic [3:0] n,
                          input bit irq_kind);
    wait_ev(1'b0);
    `CHK(daddr, a)
    `CHK(npar, n)
    if (irq_kind)
      `CHK(prio, p)
  endtask

  task automatic chk_halt(input logic [5:0] hc);
    logic [31:0] e;
    wait_ev(1'b1);
    e = {status_w[31:16], map_en, ~svalid, hc, status_w[7:0]};
    `CHK(pcl, 32'hE004_0000)
    `CHK(stl, 32'h041F_0000)
    `CHK(mapo, 1'b0)
    rd(8'h10, pc);
    wb(1'b0, 8'h14, 32'h0);
    `CHK(q[13:8], hc)
    if (hc != 6'h03)
      `CHK(q, e)
  endtask

  task automatic nest(input logic [5:0] c);
    ncode <= c;
    pulse(4);
    chk_halt(c);
  endtask

  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk_halt(6'h03);
    wb(1'b1, 8'h00, BASE);
    rd(8'h00, BASE);
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, 8'h04, {25'h0, i[0], 6'h0});
      wb(1'b1, 8'h08, 32'h0000_5A00 + 32'(i));
      code <= 16'h0010 + 16'(i < 2 ? i : 2);
      rok <= i[0];
      faddr <= 32'hA000_0000 + 32'(i);
      raddr <= 32'hB000_0000 + 32'(i);
      fetch <= 32'h0000_4000 + 32'(16 * i);
      pc <= 32'h0000_1000 + 32'(3 * i);
      bpc <= 32'h0000_1000;
      acc <= acc_tab[i];
      dlen <= 2'(i);
      opc <= 8'hC0 + 8'(i);
      dreg <= 4'(i) ^ 4'hA;
      pulse(0);
      chk_disp(BASE + 32'h4, 5'h00, 4'h6, 1'b0);
      rd(8'h20, 32'h0000_0018);
      rd(8'h24, {rok, 15'h0, code});
      rd(8'h28, (i < 2) ? raddr : faddr);
      rd(8'h2C, fetch + 32'h4);
      rd(8'h30, {9'h0, i[0], 6'h0, 16'h5A00 + 16'(i)});
      rd(8'h34, {8'(3 * i), 3'h0, acc, dlen, opc, 4'h0, dreg});
      wb(1'b1, 8'h18, 32'h1);
    end
    rd(8'h18, 32'h0);
    pulse(1);
    chk_disp(BASE + 32'h20, 5'h00, 4'h2, 1'b0);
    pulse(2);
    chk_disp(BASE + 32'h24, 5'h00, 4'h2, 1'b0);
    pulse(0);
    chk_disp(BASE + 32'h4, 5'h00, 4'h6, 1'b0);
    pulse(0);
    chk_halt(6'h12);
    ksnv <= 1'b1;
    pulse(0);
    chk_halt(6'h13);
    pulse(2);
    chk_halt(6'h11);
    ksnv <= 1'b0;
    pulse(0);
    chk_disp(BASE + 32'h4, 5'h00, 4'h6, 1'b0);
    pulse(1);
    chk_halt(6'h10);
    nest(6'h04);
    nest(6'h05);
    nest(6'h0A);
    kmode <= 1'b1;
    status_w <= 32'h8765_00C3;
    map_en <= 1'b1;
    pulse(3);
    chk_halt(6'h06);
    svalid <= 1'b0;
    hpin_n <= 1'b0;
    chk_halt(6'h02);
    hpin_n <= 1'b1;
    rd(8'h04, 32'h0000_0040);
    fork
      irq.send(5'h15, 16'h0104, 3);
      chk_disp(BASE + 32'h104, 5'h15, 4'h0, 1'b1);
    join
    fork
      irq.send(5'h17, 16'h0200, 8);
      chk_disp(BASE + 32'h200, 5'h17, 4'h0, 1'b1);
    join
    fork
      irq.send(5'h14, 16'h0107, 3);
      chk_halt(6'h07);
    join
    fork
      irq.send(5'h14, 16'h0106, 3);
      chk_halt(6'h08);
    join
    wb(1'b1, 8'h0C, 32'h0000_0005);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk_halt(6'h03);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
